/* logic/fpsm_core.sv */
`timescale 1ns/10ps
module fpsm_core (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic prog_high_i,
  input wire logic prog_mid_i,
  input wire logic [fpsm_pkg::W_SENS-1:0] fuse_sens_i,
  input wire logic [fpsm_pkg::W_FINE-1:0] fuse_fine_i,
  input wire logic [fpsm_pkg::W_FREQ-1:0] fuse_freq_i,
  input wire logic [fpsm_pkg::W_CAL-1:0] fuse_cal_i,
  output logic [fpsm_pkg::W_SENS-1:0] sens_code_o,
  output logic [fpsm_pkg::W_FINE-1:0] fine_duty_code_o,
  output logic [fpsm_pkg::W_FREQ-1:0] freq_code_o,
  output logic [fpsm_pkg::W_CAL-1:0] cal_code_o,
  output logic coarse_duty_en_o,
  output logic duty_decrease_o,
  output logic slow_freq_o,
  output logic cal_test_en_o,
  output logic locked_o,
  output logic try_mode_o,
  output logic [4:0] prog_state_o,
  output logic fuse_blow_o,
  output logic [2:0] fuse_blow_key_o,
  output logic [3:0] fuse_blow_bit_o
);
  import fpsm_pkg::*;

  // ----------------------------------------
  // pulse qualification
  // ----------------------------------------
  fpsm_pulse_if ev_if ();

  fpsm_pulse_qual #(.FILT_CYC(FILT_CYC)) u_qual (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .lvl_high_i(prog_high_i),
    .lvl_mid_i(prog_mid_i),
    .ev(ev_if.src)
  );

  wire hi_ev = ev_if.hi_ev;
  wire mid_ev = ev_if.mid_ev;

  // ----------------------------------------
  // fuse state synchroniser
  // ----------------------------------------
  wire [CW-1:0] fuse_raw [0:NREG-1];
  logic [CW-1:0] fuse_s1 [0:NREG-1];
  logic [CW-1:0] fuse_s2 [0:NREG-1];

  assign fuse_raw[SLOT_SENS] = {{(CW-W_SENS){1'b0}}, fuse_sens_i};
  assign fuse_raw[SLOT_FINE] = {{(CW-W_FINE){1'b0}}, fuse_fine_i};
  assign fuse_raw[SLOT_FREQ] = {{(CW-W_FREQ){1'b0}}, fuse_freq_i};
  assign fuse_raw[SLOT_CAL] = fuse_cal_i;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        fuse_s1[i] <= CODE_RST;
        fuse_s2[i] <= CODE_RST;
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        fuse_s1[i] <= fuse_raw[i];
        fuse_s2[i] <= fuse_s1[i];
      end
    end
  end

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  fpsm_state_e state, next_state;
  logic [2:0] mode_key;
  logic [2:0] key;
  logic hi_seen;
  logic [1:0] slot;
  logic slot_ok;
  logic [CW-1:0] trial [0:NREG-1];
  logic [CW-1:0] value_q [0:NREG-1];

  function automatic logic [3:0] top_bit(input logic [CW-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < CW; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  wire locked = fuse_s2[SLOT_CAL][LOCK_BIT];
  wire is_try = (mode_key == KEY_MODE_TRY);
  wire mode_ok = (mode_key == KEY_MODE_BLOW) || is_try;
  wire [1:0] key_slot = (key == KEY_SENS) ? SLOT_SENS :
                        (key == KEY_FINE) ? SLOT_FINE :
                        (key == KEY_FREQ) ? SLOT_FREQ : SLOT_CAL;
  // key four and unused keys address nothing
  wire key_ok = (key == KEY_SENS) || (key == KEY_FINE) || (key == KEY_FREQ) || (key == KEY_CAL);
  wire [CW-1:0] cur_code = trial[slot];
  wire at_max = (cur_code >= CODE_MAX[slot]);
  wire [CW-1:0] blow_cand = cur_code & ~fuse_s2[slot];
  wire blow_any = |blow_cand;
  wire [3:0] blow_bit = top_bit(blow_cand);
  wire [2:0] slot_key = (slot == SLOT_SENS) ? KEY_SENS :
                        (slot == SLOT_FINE) ? KEY_FINE :
                        (slot == SLOT_FREQ) ? KEY_FREQ : KEY_CAL;
  wire do_inc = (state == ST_FIELD) && mid_ev && slot_ok && !at_max;
  wire do_blow = (state == ST_FIELD) && hi_ev && !is_try && slot_ok && blow_any;
  wire enter_field = (state == ST_PARAM) && hi_ev;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_INIT: begin
        if (hi_ev && !locked) begin
          next_state = ST_MODE;
        end
      end
      ST_MODE: begin
        if (hi_ev && hi_seen) begin
          next_state = mode_ok ? ST_PARAM : ST_INIT;
        end
      end
      ST_PARAM: begin
        if (hi_ev) begin
          next_state = ST_FIELD;
        end
      end
      ST_FIELD: begin
        if (hi_ev) begin
          next_state = is_try ? ST_PARAM : ST_BLOWN;
        end
      end
      ST_BLOWN: begin
        next_state = ST_BLOWN;
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // mode key and high-pulse pairing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_key <= 3'h0;
      hi_seen <= 1'b0;
    end else if (state == ST_INIT) begin
      // a refused mode key must not carry over into the next mode select
      mode_key <= 3'h0;
      hi_seen <= 1'b0;
    end else if (state == ST_MODE) begin
      if (mid_ev && mode_key != KEY_MAX) begin
        mode_key <= mode_key + 3'h1;
      end
      if (hi_ev) begin
        hi_seen <= !hi_seen;
      end
    end
  end

  // parameter key and latched selection
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      key <= 3'h0;
      slot <= SLOT_SENS;
      slot_ok <= 1'b0;
    end else if (state == ST_PARAM) begin
      if (mid_ev && key != KEY_MAX) begin
        key <= key + 3'h1;
      end
      if (hi_ev) begin
        slot <= key_slot;
        slot_ok <= key_ok;
        key <= 3'h0;
      end
    end
  end

  // ----------------------------------------
  // trial codes
  // ----------------------------------------
  // entering a field restarts its code from the blown pattern
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        trial[i] <= CODE_RST;
      end
    end else if (enter_field && key_ok) begin
      trial[key_slot] <= fuse_s2[key_slot];
    end else if (do_inc) begin
      trial[slot] <= cur_code + 10'h001;
    end
  end

  // blown bits are forced to one in the applied value
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        value_q[i] <= CODE_RST;
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        value_q[i] <= trial[i] | fuse_s2[i];
      end
    end
  end

  // ----------------------------------------
  // fuse blow request
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fuse_blow_o <= 1'b0;
      fuse_blow_key_o <= 3'h0;
      fuse_blow_bit_o <= 4'h0;
    end else begin
      fuse_blow_o <= do_blow;
      if (do_blow) begin
        fuse_blow_key_o <= slot_key;
        fuse_blow_bit_o <= blow_bit;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked_o <= 1'b0;
      try_mode_o <= 1'b0;
      prog_state_o <= ST_INIT;
    end else begin
      locked_o <= locked;
      try_mode_o <= is_try && (state != ST_INIT) && (state != ST_MODE);
      prog_state_o <= state;
    end
  end

  assign sens_code_o = value_q[SLOT_SENS][W_SENS-1:0];
  assign fine_duty_code_o = value_q[SLOT_FINE][W_FINE-1:0];
  assign freq_code_o = value_q[SLOT_FREQ][W_FREQ-1:0];
  assign cal_code_o = value_q[SLOT_CAL][W_CAL-1:0];
  assign coarse_duty_en_o = value_q[SLOT_SENS][SENS_COARSE_BIT];
  assign duty_decrease_o = value_q[SLOT_FINE][FINE_DOWN_BIT];
  assign slow_freq_o = value_q[SLOT_FREQ][FREQ_SLOW_BIT];
  assign cal_test_en_o = value_q[SLOT_CAL][CAL_TEST_BIT];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_init_ignores_mid: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_INIT) && !hi_ev |=> (state == ST_INIT)
  ) else $error("initial state left without a high pulse");

  a_init_to_mode: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_INIT) && hi_ev && !locked |=> (state == ST_MODE) ##1 (prog_state_o == ST_MODE)
  ) else $error("high pulse did not reach mode select");

  a_mode_key_count: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_MODE) && mid_ev && (mode_key < KEY_MAX) |=> (mode_key == $past(mode_key) + 3'h1)
  ) else $error("mode key did not advance");

  a_mode_two_high: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_MODE) && hi_ev && !hi_seen |=> (state == ST_MODE)
  ) else $error("mode select left on first high pulse");

  a_param_key_count: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_PARAM) && mid_ev && !hi_ev && (key < KEY_MAX) |=> (key == $past(key) + 3'h1)
  ) else $error("parameter key did not advance");

  a_param_to_field: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_PARAM) && hi_ev |=> (state == ST_FIELD) && (slot_ok == $past(key_ok))
  ) else $error("bitfield select not entered");

  a_code_increments: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    do_inc |=> (trial[$past(slot)] == $past(cur_code) + 10'h001) ##1 (value_q[$past(slot, 2)] != CODE_RST)
  ) else $error("code did not step by one");

  a_code_saturates: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_FIELD) && mid_ev && at_max |=> (trial[$past(slot)] == $past(cur_code))
  ) else $error("code passed its maximum");

  a_try_returns: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_FIELD) && hi_ev && is_try |=> (state == ST_PARAM) && !fuse_blow_o
  ) else $error("try mode did not return to parameter select");

  a_try_never_blows: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    fuse_blow_o |-> !$past(is_try) && $past(state == ST_FIELD)
  ) else $error("fuse blown outside blow mode field state");

  a_blow_holds: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_BLOWN) |=> (state == ST_BLOWN) && !fuse_blow_o
  ) else $error("blow session continued after blowing");

  a_no_decrement: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_FIELD) && !$past(enter_field) |-> (trial[slot] >= $past(trial[slot]))
  ) else $error("addressed code went down");

  a_blown_reads_one: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ((value_q[SLOT_FINE] & $past(fuse_s2[SLOT_FINE])) == $past(fuse_s2[SLOT_FINE]))
  ) else $error("blown bit read as zero");

  a_lock_refuses: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    locked && (state == ST_INIT) |=> (state == ST_INIT) [*2]
  ) else $error("locked device accepted programming");
endmodule

/* logic/fpsm_pkg.sv */
package fpsm_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_ACTIVE_US = 40;
  localparam int ACTIVE_CYC = (T_ACTIVE_US * 1000) / CLK_PERIOD_NS;
  // glitch filter is an eighth of the shortest legal pulse
  localparam int FILT_CYC = ACTIVE_CYC / 8;

  // ----------------------------------------
  // keys and registers
  // ----------------------------------------
  localparam logic [2:0] KEY_MODE_BLOW = 3'h1;
  localparam logic [2:0] KEY_MODE_TRY = 3'h2;
  localparam logic [2:0] KEY_SENS = 3'h1;
  localparam logic [2:0] KEY_FINE = 3'h2;
  localparam logic [2:0] KEY_FREQ = 3'h3;
  localparam logic [2:0] KEY_NULL = 3'h4;
  localparam logic [2:0] KEY_CAL = 3'h5;
  localparam logic [2:0] KEY_MAX = 3'h7;
  localparam int NREG = 4;
  localparam int CW = 10;
  localparam int W_SENS = 9;
  localparam int W_FINE = 9;
  localparam int W_FREQ = 6;
  localparam int W_CAL = 10;
  localparam logic [1:0] SLOT_SENS = 2'h0;
  localparam logic [1:0] SLOT_FINE = 2'h1;
  localparam logic [1:0] SLOT_FREQ = 2'h2;
  localparam logic [1:0] SLOT_CAL = 2'h3;
  localparam logic [CW-1:0] CODE_MAX [0:NREG-1] = '{10'h1FF, 10'h1FF, 10'h03F, 10'h3FF};
  localparam logic [CW-1:0] CODE_RST = 10'h000;
  localparam int SENS_COARSE_BIT = 8;
  localparam int FINE_DOWN_BIT = 8;
  localparam int FREQ_SLOW_BIT = 4;
  localparam int CAL_TEST_BIT = 4;
  localparam int LOCK_BIT = 9;

  typedef enum logic [4:0] {
    ST_INIT = 5'h01,
    ST_MODE = 5'h02,
    ST_PARAM = 5'h04,
    ST_FIELD = 5'h08,
    ST_BLOWN = 5'h10
  } fpsm_state_e;
endpackage

/* logic/fpsm_pulse_if.sv */
`timescale 1ns/10ps
interface fpsm_pulse_if;
  logic hi_ev;
  logic mid_ev;
  modport src (output hi_ev, output mid_ev);
  modport snk (input hi_ev, input mid_ev);
endinterface

/* logic/fpsm_pulse_qual.sv */
`timescale 1ns/10ps
module fpsm_pulse_qual #(
  parameter int FILT_CYC = 50
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic lvl_high_i,
  input wire logic lvl_mid_i,
  fpsm_pulse_if.src ev
);
  logic hs1, hs2, ms1, ms2;
  logic [1:0] cand, stable, peak;
  logic [15:0] cnt;

  // ----------------------------------------
  // level classification
  // ----------------------------------------
  wire [1:0] raw_lvl = hs2 ? 2'h2 : (ms2 ? 2'h1 : 2'h0);
  wire settled = (raw_lvl == cand) && (cnt >= 16'(FILT_CYC));
  wire pulse_end = settled && (cand == 2'h0) && (stable != 2'h0);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs1 <= 1'b0;
      hs2 <= 1'b0;
      ms1 <= 1'b0;
      ms2 <= 1'b0;
    end else begin
      hs1 <= lvl_high_i;
      hs2 <= hs1;
      ms1 <= lvl_mid_i;
      ms2 <= ms1;
    end
  end

  // glitch filter: a level counts only once it has held FILT_CYC cycles
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cand <= 2'h0;
      cnt <= 16'h0000;
      stable <= 2'h0;
      peak <= 2'h0;
    end else if (raw_lvl != cand) begin
      cand <= raw_lvl;
      cnt <= 16'h0000;
    end else if (!settled) begin
      cnt <= cnt + 16'h0001;
    end else begin
      stable <= cand;
      if (cand == 2'h0) begin
        peak <= 2'h0;
      end else if (cand > peak) begin
        peak <= cand;
      end
    end
  end

  // events fire when the pulse falls back to low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev.hi_ev <= 1'b0;
      ev.mid_ev <= 1'b0;
    end else begin
      ev.hi_ev <= pulse_end && (peak == 2'h2);
      ev.mid_ev <= pulse_end && (peak == 2'h1);
    end
  end
endmodule

/* verif/fpsm_prog_model.sv */
`timescale 1ns/10ps
module fpsm_prog_model (
  input wire logic core_clk_i,
  input wire logic fuse_blow_i,
  input wire logic [2:0] fuse_blow_key_i,
  input wire logic [3:0] fuse_blow_bit_i,
  output logic prog_high_o,
  output logic prog_mid_o,
  output logic [fpsm_pkg::W_SENS-1:0] fuse_sens_o,
  output logic [fpsm_pkg::W_FINE-1:0] fuse_fine_o,
  output logic [fpsm_pkg::W_FREQ-1:0] fuse_freq_o,
  output logic [fpsm_pkg::W_CAL-1:0] fuse_cal_o
);
  import fpsm_pkg::*;
  int blow_cnt;

  initial begin
    prog_high_o = 1'b0;
    prog_mid_o = 1'b0;
    fuse_sens_o = '0;
    fuse_fine_o = '0;
    fuse_freq_o = '0;
    fuse_cal_o = '0;
    blow_cnt = 0;
  end

  // ----------------------------------------
  // supply pulses
  // ----------------------------------------
  // a high pulse passes through the mid level, so both comparators are up
  task automatic send(input logic high);
    @(negedge core_clk_i);
    prog_mid_o = 1'b1;
    prog_high_o = high;
    repeat (ACTIVE_CYC) @(negedge core_clk_i);
    prog_mid_o = 1'b0;
    prog_high_o = 1'b0;
    repeat (ACTIVE_CYC) @(negedge core_clk_i);
  endtask

  // register select uses one high pulse, mode select two
  task automatic train(input logic high, input int n);
    repeat (n) send(high);
  endtask

  // ----------------------------------------
  // fuse array
  // ----------------------------------------
  // a blown fuse stays set for good; only one bit per request
  always @(posedge core_clk_i) begin
    if (fuse_blow_i) begin
      blow_cnt <= blow_cnt + 1;
      case (fuse_blow_key_i)
        KEY_SENS: fuse_sens_o[fuse_blow_bit_i] <= 1'b1;
        KEY_FINE: fuse_fine_o[fuse_blow_bit_i] <= 1'b1;
        KEY_FREQ: fuse_freq_o[fuse_blow_bit_i] <= 1'b1;
        KEY_CAL: fuse_cal_o[fuse_blow_bit_i] <= 1'b1;
        default: blow_cnt <= blow_cnt + 1000;
      endcase
    end
  end
endmodule

/* verif/tb_fuse_programming_state_machine.sv */
`timescale 1ns/10ps
module tb_fuse_programming_state_machine;
  import fpsm_pkg::*;
  localparam logic HI = 1'b1;
  localparam logic MI = 1'b0;
  logic core_clk_i, rst_i, prog_high_i, prog_mid_i;
  logic [W_SENS-1:0] fuse_sens_i, sens_code_o;
  logic [W_FINE-1:0] fuse_fine_i, fine_duty_code_o;
  logic [W_FREQ-1:0] fuse_freq_i, freq_code_o;
  logic [W_CAL-1:0] fuse_cal_i, cal_code_o;
  logic coarse_duty_en_o, duty_decrease_o, slow_freq_o, cal_test_en_o, locked_o, try_mode_o, fuse_blow_o;
  logic [4:0] prog_state_o;
  logic [2:0] fuse_blow_key_o;
  logic [3:0] fuse_blow_bit_o;
  int miscompares = 0;
  int num_checks = 0;

  fpsm_core i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .prog_high_i(prog_high_i), .prog_mid_i(prog_mid_i),
    .fuse_sens_i(fuse_sens_i), .fuse_fine_i(fuse_fine_i), .fuse_freq_i(fuse_freq_i), .fuse_cal_i(fuse_cal_i),
    .sens_code_o(sens_code_o), .fine_duty_code_o(fine_duty_code_o), .freq_code_o(freq_code_o),
    .cal_code_o(cal_code_o), .coarse_duty_en_o(coarse_duty_en_o), .duty_decrease_o(duty_decrease_o),
    .slow_freq_o(slow_freq_o), .cal_test_en_o(cal_test_en_o), .locked_o(locked_o), .try_mode_o(try_mode_o),
    .prog_state_o(prog_state_o), .fuse_blow_o(fuse_blow_o), .fuse_blow_key_o(fuse_blow_key_o),
    .fuse_blow_bit_o(fuse_blow_bit_o));

  fpsm_prog_model i_prog (.core_clk_i(core_clk_i), .fuse_blow_i(fuse_blow_o), .fuse_blow_key_i(fuse_blow_key_o),
    .fuse_blow_bit_i(fuse_blow_bit_o), .prog_high_o(prog_high_i), .prog_mid_o(prog_mid_i),
    .fuse_sens_o(fuse_sens_i), .fuse_fine_o(fuse_fine_i), .fuse_freq_o(fuse_freq_i), .fuse_cal_o(fuse_cal_i));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [CW-1:0] got, input logic [CW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_st(input logic [4:0] exp);
    num_checks++;
    if (prog_state_o !== exp) begin
      miscompares++;
      $display("[FAIL] %0t state %h expected %h", $time, prog_state_o, exp);
    end
  endtask

  // supply cycle: fuses are sampled after release, so let them settle
  task automatic power_up;
    @(negedge core_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (8) @(negedge core_clk_i);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk_i);
    miscompares++;
    $display("[FAIL] %0t run limit reached", $time);
    end_of_test;
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    @(negedge core_clk_i);
    i_prog.fuse_freq_o = 6'h3E;
    power_up();
    chk_st(ST_INIT);
    chk_v(CW'(sens_code_o), 10'h000);
    i_prog.send(MI);
    chk_st(ST_INIT);
    i_prog.send(HI);
    chk_st(ST_MODE);
    i_prog.train(MI, 2);
    i_prog.train(HI, 2);
    chk_st(ST_PARAM);
    chk_v(CW'(try_mode_o), 10'h001);
    i_prog.send(MI);
    i_prog.send(HI);
    chk_st(ST_FIELD);
    i_prog.train(MI, 3);
    chk_v(CW'(sens_code_o), 10'h003);
    i_prog.send(HI);
    chk_st(ST_PARAM);
    i_prog.train(MI, 2);
    i_prog.send(HI);
    i_prog.train(MI, 2);
    chk_v(CW'(fine_duty_code_o), 10'h002);
    chk_v(CW'(sens_code_o), 10'h003);
    i_prog.send(HI);
    i_prog.train(MI, 3);
    i_prog.send(HI);
    i_prog.send(MI);
    chk_v(CW'(freq_code_o), 10'h03F);
    chk_v(CW'(slow_freq_o), 10'h001);
    i_prog.send(MI);
    chk_v(CW'(freq_code_o), 10'h03F);
    // park on the null register before measuring
    i_prog.send(HI);
    i_prog.train(MI, 4);
    i_prog.send(HI);
    i_prog.send(MI);
    chk_v(CW'(sens_code_o + fine_duty_code_o), 10'h005);
    chk_v(CW'(i_prog.blow_cnt), 10'h000);
    power_up();
    chk_v(CW'(sens_code_o), 10'h000);
    i_prog.send(HI);
    i_prog.send(MI);
    i_prog.train(HI, 2);
    chk_v(CW'(try_mode_o), 10'h000);
    i_prog.train(MI, 2);
    i_prog.send(HI);
    i_prog.train(MI, 4);
    chk_st(ST_FIELD);
    chk_v(CW'(fine_duty_code_o), 10'h004);
    i_prog.send(HI);
    chk_v(CW'(i_prog.blow_cnt), 10'h001);
    chk_v(CW'(fuse_blow_key_o), 10'h002);
    chk_v(CW'(fuse_blow_bit_o), 10'h002);
    chk_v(CW'(fuse_fine_i), 10'h004);
    chk_st(ST_BLOWN);
    i_prog.send(HI);
    chk_st(ST_BLOWN);
    chk_v(CW'(i_prog.blow_cnt), 10'h001);
    power_up();
    chk_v(CW'(fine_duty_code_o), 10'h004);
    // a mode key of three is refused and falls back to the initial state
    i_prog.send(HI);
    i_prog.train(MI, 3);
    i_prog.train(HI, 2);
    chk_st(ST_INIT);
    i_prog.send(HI);
    i_prog.train(MI, 2);
    i_prog.train(HI, 2);
    i_prog.train(MI, 2);
    i_prog.send(HI);
    i_prog.send(MI);
    chk_v(CW'(fine_duty_code_o), 10'h005);
    @(negedge core_clk_i);
    i_prog.fuse_sens_o = 9'h100;
    i_prog.fuse_fine_o = 9'h104;
    i_prog.fuse_cal_o = 10'h210;
    power_up();
    chk_v(CW'(coarse_duty_en_o), 10'h001);
    chk_v(CW'(duty_decrease_o), 10'h001);
    chk_v(CW'(cal_test_en_o), 10'h001);
    chk_v(cal_code_o, 10'h210);
    chk_v(CW'(locked_o), 10'h001);
    i_prog.send(HI);
    chk_st(ST_INIT);
    end_of_test;
  end
endmodule
